/* File: hw/dec_monitor.sv */
// dual 40-bit event / duration counter with control register and monitor pins
// assumes event inputs and privilege level synchronous to clk; software-side ops
// arrive as one-cycle strobes from the core's model register unit
`timescale 1ns/100ps
module dec_monitor
   import dec_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   // core state and event sources
   input wire logic [1:0] current_privilege_level,
   input wire logic [63:0] event_hit,
   input wire logic [63:0] event_double,
   input wire logic [63:0] condition_true,
   // model register access
   input wire logic model_register_read_op,
   input wire logic model_register_write_op,
   input wire logic [1:0] reg_select,
   input wire logic [39:0] reg_wdata,
   output logic [39:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_fault,
   // debugger pin takeover
   input wire logic breakpoint_mode,
   input wire logic [1:0] breakpoint_match,
   // monitor pins
   output logic monitor_pin_a,
   output logic monitor_pin_b,
   // current control value, for observation
   output logic [31:0] count_control_register
);
   logic rst_sync1;
   logic rst_n;
   logic [CNT_W-1:0] event_counter_0;
   logic [CNT_W-1:0] event_counter_1;
   logic priv_ok;
   logic wr_ok;
   logic rd_ok;

   // reset released through two flops; asserts asynchronously
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync1 <= 1'b1;
         rst_n <= rst_sync1;
      end
   end

   assign priv_ok = (current_privilege_level == PL_KERNEL);
   assign wr_ok = model_register_write_op && priv_ok;
   assign rd_ok = model_register_read_op && priv_ok;

   // per-counter decode
   logic [CODE_W-1:0] code [2];
   logic [2:0] mode [2];
   logic pin_ovf [2];
   logic [1:0] inc_amt [2];
   logic counting [2];
   logic ovf [2];
   logic [CNT_W:0] sum [2];

   assign code[0] = count_control_register[CODE_A_LSB +: CODE_W];
   assign code[1] = count_control_register[CODE_B_LSB +: CODE_W];
   assign mode[0] = count_control_register[MODE_A_LSB +: 3];
   assign mode[1] = count_control_register[MODE_B_LSB +: 3];
   assign pin_ovf[0] = count_control_register[PINF_A_BIT];
   assign pin_ovf[1] = count_control_register[PINF_B_BIT];

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         logic lvl_ok;
         logic hit;
         lvl_ok = 1'b0;
         hit = 1'b0;
         // modes 000 and 100 enable no level, so nothing counts
         lvl_ok = (current_privilege_level == PL_USER) ? mode[i][1] : mode[i][0];
         if (mode[i][2]) begin
            // duration: one per clock the condition holds
            hit = condition_true[code[i]];
            inc_amt[i] = (lvl_ok && hit) ? 2'h1 : 2'h0;
         end else begin
            // occurrences: up to two per clock
            hit = event_hit[code[i]];
            inc_amt[i] = !(lvl_ok && hit) ? 2'h0 : (event_double[code[i]] ? 2'h2 : 2'h1);
         end
         counting[i] = (inc_amt[i] != 2'h0);
      end
   end

   assign sum[0] = {1'b0, event_counter_0} + {39'h0, inc_amt[0]};
   assign sum[1] = {1'b0, event_counter_1} + {39'h0, inc_amt[1]};
   // carry out of bit 39 is overflow
   assign ovf[0] = sum[0][CNT_W];
   assign ovf[1] = sum[1][CNT_W];

   // control register: whole-word writes only, software keeps the other half
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_control_register <= CTRL_RESET;
      end else if (wr_ok && reg_select == SEL_CTRL) begin
         count_control_register <= reg_wdata[31:0] & CTRL_MASK;
      end
   end

   // counters: a software write wins over counting in that clock, so a preset
   // lands exactly; stop-then-preset before event change is software's job
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         event_counter_0 <= CNT_RESET;
      end else if (wr_ok && reg_select == SEL_CNT0) begin
         event_counter_0 <= reg_wdata;
      end else begin
         event_counter_0 <= sum[0][CNT_W-1:0]; // wraps to zero
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         event_counter_1 <= CNT_RESET;
      end else if (wr_ok && reg_select == SEL_CNT1) begin
         event_counter_1 <= reg_wdata;
      end else begin
         event_counter_1 <= sum[1][CNT_W-1:0]; // wraps to zero
      end
   end

   // read answer one clock after the op; denied ops flag a fault instead
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= CNT_RESET;
         reg_rvalid <= 1'b0;
         reg_fault <= 1'b0;
      end else begin
         reg_rvalid <= rd_ok;
         reg_fault <= (model_register_read_op || model_register_write_op) && !priv_ok;
         if (rd_ok) begin
            unique case (reg_select)
               SEL_CTRL: reg_rdata <= {8'h00, count_control_register};
               SEL_CNT0: reg_rdata <= event_counter_0;
               SEL_CNT1: reg_rdata <= event_counter_1;
               default: reg_rdata <= 40'h00_0000_0000;
            endcase
         end
      end
   end

   // pin path: increment indication registered twice (one pulse per clock even
   // when adding two, held through a duration interval); overflow runs through
   // the five-stage delay line and the pin flop so it appears six clocks later
   logic inc_q [2];
   logic ovf_late [2];
   logic pin_q [2];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin
         dec_delay_line #(
            .DEPTH(OVF_DELAY_CLK)
         ) u_ovf_delay (
            .clk(clk),
            .rst_n(rst_n),
            .d(ovf[g] && !(wr_ok && reg_select == (g == 0 ? SEL_CNT0 : SEL_CNT1))),
            .q(ovf_late[g])
         );

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               inc_q[g] <= 1'b0;
               pin_q[g] <= 1'b0;
            end else begin
               inc_q[g] <= counting[g];
               if (breakpoint_mode) begin
                  pin_q[g] <= breakpoint_match[g];
               end else if (pin_ovf[g]) begin
                  pin_q[g] <= ovf_late[g];
               end else begin
                  pin_q[g] <= inc_q[g];
               end
            end
         end
      end
   endgenerate

   assign monitor_pin_a = pin_q[0];
   assign monitor_pin_b = pin_q[1];
endmodule

/* File: hw/dec_pkg.sv */
// package for the dual event counter monitor: register selects, field positions, timing
// assumes one core clock; registers reached through model register read/write ops
package dec_pkg;
   localparam int CNT_W = 40;
   localparam int CODE_W = 6;
   // register selects carried on the model register op address
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_CNT0 = 2'h1;
   localparam logic [1:0] SEL_CNT1 = 2'h2;
   // field positions inside count_control_register
   localparam int CODE_A_LSB = 0;
   localparam int MODE_A_LSB = 6;
   localparam int PINF_A_BIT = 9;
   localparam int CODE_B_LSB = 16;
   localparam int MODE_B_LSB = 22;
   localparam int PINF_B_BIT = 25;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'h03FF_03FF;
   localparam logic [39:0] CNT_RESET = 40'h00_0000_0000;
   // overflow indication delay, in clocks
   localparam int OVF_DELAY_CLK = 5;
   localparam logic [1:0] PL_KERNEL = 2'h0;
   localparam logic [1:0] PL_USER = 2'h3;
endpackage

/* File: hw/dec_delay_line.sv */
// fixed delay line of single-bit pulses
// assumes a synchronous clock and the released internal reset
`timescale 1ns/100ps
module dec_delay_line #(
   parameter int DEPTH = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic [DEPTH-1:0] stage;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage <= '0;
      end else begin
         stage <= {stage[DEPTH-2:0], d};
      end
   end

   assign q = stage[DEPTH-1];
endmodule

/* File: tb/dec_chk_monitor.sv */
// port checker for the dual event counter monitor
// assumes binding onto dec_monitor and one clock domain
`timescale 1ns/100ps
module dec_chk
   import dec_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [1:0] current_privilege_level,
   input wire logic model_register_read_op,
   input wire logic model_register_write_op,
   input wire logic [1:0] reg_select,
   input wire logic [39:0] reg_wdata,
   input wire logic reg_fault,
   input wire logic [31:0] count_control_register,
   input wire logic [63:0] condition_true,
   input wire logic breakpoint_mode,
   input wire logic [1:0] breakpoint_match,
   input wire logic monitor_pin_a,
   input wire logic monitor_pin_b
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire logic op = model_register_read_op | model_register_write_op;
   wire logic user = current_privilege_level != PL_KERNEL;
   wire logic ctrl_wr = model_register_write_op && !user && reg_select == SEL_CTRL;
   // three clocks of held condition cover the two-flop pin path
   sequence s_dur_a;
      (count_control_register[8:6] == 3'h7 && !count_control_register[9]
         && condition_true[count_control_register[5:0]] && !breakpoint_mode) [*3];
   endsequence
   sequence s_idle;
      (count_control_register == CTRL_RESET && !breakpoint_mode) [*8];
   endsequence
   a_user_fault: assert property (op && user |=> reg_fault)
      else $error("user level op not faulted");
   a_fault_cause: assert property (reg_fault |-> $past(op && user))
      else $error("fault without user level op");
   a_ctrl_load: assert property (ctrl_wr |=> count_control_register ==
      ($past(reg_wdata[31:0]) & CTRL_MASK)) else $error("control write not loaded");
   a_ctrl_hold: assert property (!ctrl_wr |=> $stable(count_control_register))
      else $error("control changed without write");
   a_reset_clear: assert property ($rose(rstn) |-> count_control_register == CTRL_RESET)
      else $error("control not clear after reset");
   a_dur_pin: assert property (s_dur_a |-> monitor_pin_a)
      else $error("duration pin dropped");
   a_idle_pins: assert property (s_idle |-> !monitor_pin_a && !monitor_pin_b)
      else $error("pin active while disabled");
   a_bp_pins: assert property (breakpoint_mode [*2] |-> {monitor_pin_b, monitor_pin_a}
      == $past(breakpoint_match)) else $error("pins not showing breakpoint match");
endmodule
bind dec_monitor dec_chk u_dec_chk (.clk(clk), .rstn(rstn),
   .current_privilege_level(current_privilege_level),
   .model_register_read_op(model_register_read_op),
   .model_register_write_op(model_register_write_op), .reg_select(reg_select),
   .reg_wdata(reg_wdata), .reg_fault(reg_fault), .count_control_register(count_control_register),
   .condition_true(condition_true), .breakpoint_mode(breakpoint_mode),
   .breakpoint_match(breakpoint_match), .monitor_pin_a(monitor_pin_a),
   .monitor_pin_b(monitor_pin_b));

/* File: tb/dec_pin_watch.sv */
// external watcher: counts clocks during which a monitor pin is high
// assumes the pin is registered on clk
`timescale 1ns/100ps
module dec_pin_watch (
   input wire logic clk,
   input wire logic clr,
   input wire logic pin,
   output int hits
);
   always_ff @(posedge clk) begin
      if (clr) begin
         hits <= 0;
      end else if (pin === 1'h1) begin
         hits <= hits + 1;
      end
   end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the dual event counter monitor
// assumes dec_monitor, the pin watchers and a 10 MHz clock
`timescale 1ns/100ps
module testbench;
   import dec_pkg::*;
   logic clk = 1'h0, rstn = 1'h0, rd_op = 1'h0, wr_op = 1'h0, bpm = 1'h0, clr = 1'h0;
   logic [1:0] pl = 2'h0, sel = 2'h0, bpx = 2'h0, p;
   logic [63:0] hit = 64'h0, dbl = 64'h0, cond = 64'h0;
   logic [39:0] wd = 40'h0, rdata, exp;
   logic rvalid, fault, pa, pb, en;
   logic [31:0] ccr;
   int hits_a, hits_b, failures = 0, n_checks = 0;
   dec_monitor u_dec_monitor (.clk(clk), .rstn(rstn), .current_privilege_level(pl),
      .event_hit(hit), .event_double(dbl), .condition_true(cond), .model_register_read_op(rd_op),
      .model_register_write_op(wr_op), .reg_select(sel), .reg_wdata(wd), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .reg_fault(fault), .breakpoint_mode(bpm), .breakpoint_match(bpx),
      .monitor_pin_a(pa), .monitor_pin_b(pb), .count_control_register(ccr));
   dec_pin_watch u_dec_pin_watch (.clk(clk), .clr(clr), .pin(pa), .hits(hits_a));
   dec_pin_watch u_dec_pin_watch_b (.clk(clk), .clr(clr), .pin(pb), .hits(hits_b));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic op(input logic w, input logic [1:0] s, input logic [39:0] d);
      @(posedge clk);
      {wr_op, rd_op, sel, wd} <= {w, !w, s, d};
      @(posedge clk);
      {wr_op, rd_op} <= 2'h0;
      #1;
   endtask
   task automatic rd(input logic [1:0] s, input logic [39:0] e);
      op(1'h0, s, 40'h0);
      chk("reg_rvalid", 40'h1, {39'h0, rvalid});
      chk("reg_rdata", e, rdata);
   endtask
   // stop, then clear or preset, then arm: never retarget a running counter
   task automatic setup(input logic [39:0] c0, input logic [31:0] ctl);
      op(1'h1, SEL_CTRL, 40'h0);
      op(1'h1, SEL_CNT0, c0);
      @(posedge clk) clr <= 1'h1;
      @(posedge clk) clr <= 1'h0;
      op(1'h1, SEL_CTRL, {8'h0, ctl});
   endtask
   task automatic run(input logic [1:0] lv, input int n);
      @(posedge clk) {pl, hit, dbl, cond} <= {lv, {3{64'h2}}};
      repeat (n) @(posedge clk);
      {pl, hit, dbl, cond} <= '0;
      repeat (10) @(posedge clk);
      #1;
   endtask
   task automatic summarize();
      if (failures == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      rd(SEL_CTRL, 40'h0);
      op(1'h1, SEL_CTRL, 40'hFF_FFFF_FFFF);
      rd(SEL_CTRL, 40'h03FF_03FF);
      @(posedge clk) pl <= 2'h3;
      op(1'h1, SEL_CTRL, 40'h0);
      chk("reg_fault", 40'h1, {39'h0, fault});
      @(posedge clk) pl <= 2'h0;
      rd(SEL_CTRL, 40'h03FF_03FF);
      for (int m = 0; m < 8; m++) begin
         for (int j = 0; j < 2; j++) begin
            p = j ? 2'h3 : 2'h1;
            en = (m[0] && p != 2'h3) || (m[1] && p == 2'h3);
            exp = en ? (m[2] ? 40'hA : 40'h14) : 40'h0;
            setup(40'h0, 32'(m) << 6 | 32'h1);
            run(p, 10);
            rd(SEL_CNT0, exp);
            chk("pin_a_inc", en ? 40'hA : 40'h0, 40'(hits_a));
         end
      end
      setup(40'hFF_FFFF_FFFE, 32'h0000_03C1);
      run(2'h0, 4);
      rd(SEL_CNT0, 40'h2);
      chk("pin_a_ovf", 40'h1, 40'(hits_a));
      chk("pin_b", 40'h0, 40'(hits_b));
      rd(SEL_CNT1, 40'h0);
      op(1'h1, 2'h3, 40'h5);
      rd(2'h3, 40'h0);
      @(posedge clk) {bpm, bpx} <= 3'h5;
      repeat (3) @(posedge clk);
      #1;
      chk("bp_pins", 40'h1, {38'h0, pb, pa});
      summarize();
   end
endmodule
